// ===== vrx_pkg.sv
// shared constants, types and the reciprocal square root table for the vector datapath
// ==========================================================================
// How it works
// - element selector picks second-source lane, broadcast patterns
// - single reciprocal root writes low result half
// - high form writes stored result upper half
// - high form latches source as divider upper half
// - low form merges halves, computes, stores, writes low
// - accumulator access reads slice chosen by selector
// - accumulator access writes first source into slice
// - clamped subtract uses carry flag as borrow
// - clamped subtract clears whole carry flag register
// - clamped subtract saturates lanes to signed 16 bits
// - borrow subtract writes raw difference, destination and accumulator
// - borrow subtract flags negative and nonzero per lane
// - vector xor writes destination and accumulator low
// - register xor of two general sources
// - xor immediate zero-extends immediate then xors
// - xor immediate decoded by primary opcode
`default_nettype none
package vrx_pkg;
	// ==========================================================================
	// instruction fields
	localparam int OPC_LSB = 26;
	localparam int ELEM_LSB = 21;
	localparam int DEST_ELEM_LSB = 11;
	localparam int DEST_REG_LSB = 6;
	localparam int FUNCT_LSB = 0;
	localparam int GPR_RD_LSB = 11;
	localparam int GPR_TARGET_LSB = 16;
	localparam logic [5:0] OPC_VECTOR_UNIT = 6'h12;
	localparam logic [5:0] OPC_REGISTER_OP = 6'h00;
	localparam logic [5:0] OPC_XORI = 6'h0e;
	localparam logic [5:0] FN_RSQ = 6'h34;
	localparam logic [5:0] FN_RSQH = 6'h36;
	localparam logic [5:0] FN_RSQL = 6'h35;
	localparam logic [5:0] FN_SAR = 6'h1d;
	localparam logic [5:0] FN_SUB = 6'h11;
	localparam logic [5:0] FN_SUBC = 6'h15;
	localparam logic [5:0] FN_VXOR = 6'h2c;
	localparam logic [5:0] FN_XOR = 6'h26;
	// ==========================================================================
	// register map and reset values
	localparam logic [11:0] ADDR_CARRY = 12'h000;
	localparam logic [11:0] ADDR_DIV_IN = 12'h004;
	localparam logic [11:0] ADDR_DIV_OUT = 12'h008;
	localparam logic [15:0] CARRY_RST = 16'h0000;
	localparam logic [31:0] DIV_RST = 32'h0000_0000;
	localparam logic [47:0] ACC_RST = 48'h0000_0000_0000;
	// ==========================================================================
	// arithmetic constants
	localparam logic [31:0] RSQ_ZERO_RESULT = 32'h7fff_ffff;
	localparam logic [5:0] LSHIFT_ZERO = 6'h10;
	localparam logic [16:0] SAT_MAX = 17'h0_7fff;
	localparam logic [16:0] SAT_MIN = 17'h1_8000;
	localparam logic [3:0] SLICE_HI = 4'h0;
	localparam logic [3:0] SLICE_MID = 4'h1;
	localparam logic [3:0] SLICE_LO = 4'h2;
	// ==========================================================================
	// types
	typedef enum {OP_NONE, OP_RSQ, OP_RSQH, OP_RSQL, OP_SAR, OP_SUB, OP_SUBC, OP_VXOR,
		OP_XOR, OP_XORI} vrx_op_t;
	typedef struct packed {
		logic valid;
		logic [31:0] instr;
		logic [7:0][15:0] first_vector_source;
		logic [7:0][15:0] second_vector_source;
		logic [31:0] general_source_one;
		logic [31:0] general_source_two;
	} vrx_issue_t;
	typedef struct packed {
		logic valid;
		logic [4:0] vector_destination;
		logic [7:0] lane_mask;
		logic [7:0][15:0] data;
	} vrx_vec_wb_t;
	typedef struct packed {
		logic valid;
		logic [4:0] dest;
		logic [31:0] data;
	} vrx_gpr_wb_t;
	typedef logic [15:0] vrx_rsq_tab_t [512];
	// ==========================================================================
	// table of 1/sqrt mantissas, index is {normalised bits, shift parity}
	function automatic vrx_rsq_tab_t vrx_build_table();
		vrx_rsq_tab_t t;
		longint q;
		longint x;
		longint r;
		longint v;
		for (int k = 0; k < 512; k++) begin
			q = (longint'(256 + (k >> 1))) << (k & 1);
			x = q << 32;
			r = 0;
			for (int b = 21; b >= 0; b--) begin
				if (((r | (longint'(1) << b)) * (r | (longint'(1) << b))) <= x) begin
					r = r | (longint'(1) << b);
				end
			end
			v = (longint'(1) << 37) / r;
			if (v > 131071) begin
				v = 131071;
			end
			v = v - 65536;
			t[k] = v[15:0];
		end
		return t;
	endfunction
endpackage
`default_nettype wire

// ===== vrx_datapath.sv
// execution datapath: reciprocal square root, accumulator slice access, subtract, xor
//
// Chosen here: the register addresses and the APB slave port.
`default_nettype none
module vrx_datapath (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire vrx_pkg::vrx_issue_t issue,
	output vrx_pkg::vrx_vec_wb_t vec_wb,
	output vrx_pkg::vrx_gpr_wb_t gpr_wb
);
	import vrx_pkg::*;

	localparam vrx_rsq_tab_t RECIP_SQRT_TABLE = vrx_build_table();

	// ==========================================================================
	// helpers
	function automatic logic [2:0] sel_lane(input logic [3:0] e, input logic [2:0] i);
		if (e == 4'h0) begin
			return i;
		end else if (e[3:1] == 3'h1) begin
			return {i[2:1], e[0]};
		end else if (e[3:2] == 2'h1) begin
			return {i[2], e[1:0]};
		end else if (e[3]) begin
			return e[2:0];
		end
		return i;
	endfunction

	function automatic logic [5:0] lead_zeros(input logic [31:0] v);
		logic [5:0] n;
		n = 6'h20;
		for (int b = 0; b < 32; b++) begin
			if (v[b]) begin
				n = 6'(31 - b);
			end
		end
		return n;
	endfunction

	function automatic vrx_op_t decode(input logic [31:0] w);
		logic [5:0] opc;
		logic [5:0] fn;
		opc = w[OPC_LSB +: 6];
		fn = w[FUNCT_LSB +: 6];
		if (opc == OPC_XORI) begin
			return OP_XORI;
		end
		if (opc == OPC_REGISTER_OP && fn == FN_XOR) begin
			return OP_XOR;
		end
		if (opc == OPC_VECTOR_UNIT && w[25]) begin
			case (fn)
				FN_RSQ: return OP_RSQ;
				FN_RSQH: return OP_RSQH;
				FN_RSQL: return OP_RSQL;
				FN_SAR: return OP_SAR;
				FN_SUB: return OP_SUB;
				FN_SUBC: return OP_SUBC;
				FN_VXOR: return OP_VXOR;
				default: return OP_NONE;
			endcase
		end
		return OP_NONE;
	endfunction

	// ==========================================================================
	// state
	logic [15:0] carry_flag_register;
	logic [31:0] divider_input_latch;
	logic [31:0] divider_output_latch;
	logic [7:0][47:0] acc;

	// ==========================================================================
	// decode
	vrx_op_t op;
	logic [3:0] elem;
	logic [2:0] dest_lane;
	logic [15:0] src;
	logic is_rsq_any;
	assign op = issue.valid ? decode(issue.instr) : OP_NONE;
	assign elem = issue.instr[ELEM_LSB +: 4];
	assign dest_lane = issue.instr[DEST_ELEM_LSB +: 3];
	assign src = issue.second_vector_source[elem[2:0]];
	assign is_rsq_any = (op == OP_RSQ) || (op == OP_RSQH) || (op == OP_RSQL);

	// ==========================================================================
	// per-lane arithmetic
	logic [7:0][15:0] sec_sel;
	logic [7:0][16:0] sub_raw;
	logic [7:0][15:0] sub_sat;
	logic [7:0][16:0] subc_raw;
	logic [7:0][15:0] xor_res;
	logic [7:0][15:0] sar_read;
	logic [7:0][47:0] sar_acc;
	logic [15:0] next_flags_subc;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_lane
			assign sec_sel[gi] = issue.second_vector_source[sel_lane(elem, 3'(gi))];
			assign sub_raw[gi] = {issue.first_vector_source[gi][15], issue.first_vector_source[gi]}
				- {sec_sel[gi][15], sec_sel[gi]} - {16'h0000, carry_flag_register[gi]};
			assign sub_sat[gi] = ($signed(sub_raw[gi]) > $signed(SAT_MAX)) ? SAT_MAX[15:0] :
				($signed(sub_raw[gi]) < $signed(SAT_MIN)) ? SAT_MIN[15:0] :
				sub_raw[gi][15:0];
			assign subc_raw[gi] = {1'b0, issue.first_vector_source[gi]} - {1'b0, sec_sel[gi]};
			assign next_flags_subc[gi] = subc_raw[gi][16];
			assign next_flags_subc[gi + 8] = (subc_raw[gi] != 17'h0_0000);
			assign xor_res[gi] = issue.first_vector_source[gi] ^ sec_sel[gi];
			always_comb begin
				sar_acc[gi] = acc[gi];
				sar_read[gi] = 16'h0000;
				unique case (elem)
					SLICE_HI: begin
						sar_read[gi] = acc[gi][47:32];
						sar_acc[gi][47:32] = issue.first_vector_source[gi];
					end
					SLICE_MID: begin
						sar_read[gi] = acc[gi][31:16];
						sar_acc[gi][31:16] = issue.first_vector_source[gi];
					end
					SLICE_LO: begin
						sar_read[gi] = acc[gi][15:0];
						sar_acc[gi][15:0] = issue.first_vector_source[gi];
					end
					default: begin
						sar_read[gi] = 16'h0000;
					end
				endcase
			end
		end
	endgenerate

	// ==========================================================================
	// reciprocal square root
	logic [31:0] next_div_in;
	logic [5:0] lshift;
	logic [31:0] norm;
	logic [8:0] tab_index;
	logic [15:0] tab_data;
	logic [31:0] res_raw;
	logic [4:0] rshift;
	logic [31:0] res_shift;
	logic [31:0] next_div_out;
	always_comb begin
		if (op == OP_RSQL) begin
			next_div_in = {divider_input_latch[31:16], src};
		end else if (op == OP_RSQH) begin
			next_div_in = {src, 16'h0000};
		end else begin
			next_div_in = {16'h0000, src[15] ? 16'(-src) : src};
		end
	end
	assign lshift = (next_div_in == 32'h0000_0000) ? LSHIFT_ZERO : lead_zeros(next_div_in);
	assign norm = next_div_in << lshift;
	assign tab_index = {norm[30:23], lshift[0]};
	assign tab_data = RECIP_SQRT_TABLE[tab_index];
	assign res_raw = {1'b0, 1'b1, tab_data, 14'h0000};
	assign rshift = (~lshift[4:0]) >> 1;
	assign res_shift = res_raw >> rshift;
	assign next_div_out = (src == 16'h0000) ? RSQ_ZERO_RESULT :
		src[15] ? 32'(-res_shift) : res_shift;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divider_input_latch <= DIV_RST;
		end else if (is_rsq_any) begin
			divider_input_latch <= next_div_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divider_output_latch <= DIV_RST;
		end else if (op == OP_RSQ || op == OP_RSQL) begin
			divider_output_latch <= next_div_out;
		end
	end

	// ==========================================================================
	// accumulator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= {8{ACC_RST}};
		end else begin
			for (int i = 0; i < 8; i++) begin
				unique case (op)
					OP_RSQ, OP_RSQH, OP_RSQL: acc[i][15:0] <= src;
					OP_SAR: acc[i] <= sar_acc[i];
					OP_SUB: acc[i][15:0] <= sub_raw[i][15:0];
					OP_SUBC: acc[i][15:0] <= subc_raw[i][15:0];
					OP_VXOR: acc[i][15:0] <= xor_res[i];
					default: acc[i] <= acc[i];
				endcase
			end
		end
	end

	// ==========================================================================
	// carry flags, instruction update wins over a bus write
	logic bus_write;
	assign bus_write = psel && penable && pwrite && (paddr == ADDR_CARRY);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_flag_register <= CARRY_RST;
		end else if (op == OP_SUB) begin
			carry_flag_register <= 16'h0000;
		end else if (op == OP_SUBC) begin
			carry_flag_register <= next_flags_subc;
		end else if (bus_write) begin
			carry_flag_register <= pwdata[15:0];
		end
	end

	// ==========================================================================
	// write-back
	vrx_vec_wb_t next_vec;
	always_comb begin
		next_vec.valid = 1'b1;
		next_vec.vector_destination = issue.instr[DEST_REG_LSB +: 5];
		next_vec.lane_mask = 8'hff;
		next_vec.data = vec_wb.data;
		unique case (op)
			OP_RSQ, OP_RSQL: begin
				next_vec.lane_mask = 8'(1 << dest_lane);
				next_vec.data[dest_lane] = next_div_out[15:0];
			end
			OP_RSQH: begin
				next_vec.lane_mask = 8'(1 << dest_lane);
				next_vec.data[dest_lane] = divider_output_latch[31:16];
			end
			OP_SAR: begin
				next_vec.valid = (elem == SLICE_HI) || (elem == SLICE_MID) || (elem == SLICE_LO);
				next_vec.data = sar_read;
			end
			OP_SUB: next_vec.data = sub_sat;
			OP_SUBC: begin
				for (int i = 0; i < 8; i++) begin
					next_vec.data[i] = subc_raw[i][15:0];
				end
			end
			OP_VXOR: next_vec.data = xor_res;
			default: next_vec.valid = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vec_wb <= '0;
		end else begin
			vec_wb <= next_vec;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpr_wb <= '0;
		end else if (op == OP_XOR) begin
			gpr_wb.valid <= 1'b1;
			gpr_wb.dest <= issue.instr[GPR_RD_LSB +: 5];
			gpr_wb.data <= issue.general_source_one ^ issue.general_source_two;
		end else if (op == OP_XORI) begin
			gpr_wb.valid <= 1'b1;
			gpr_wb.dest <= issue.instr[GPR_TARGET_LSB +: 5];
			gpr_wb.data <= issue.general_source_one ^ {16'h0000, issue.instr[15:0]};
		end else begin
			gpr_wb.valid <= 1'b0;
		end
	end

	// ==========================================================================
	// apb slave, zero wait states, read data captured in the setup cycle
	logic mapped;
	assign mapped = (paddr == ADDR_CARRY) || (paddr == ADDR_DIV_IN) || (paddr == ADDR_DIV_OUT);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			unique case (paddr)
				ADDR_CARRY: prdata <= {16'h0000, carry_flag_register};
				ADDR_DIV_IN: prdata <= divider_input_latch;
				ADDR_DIV_OUT: prdata <= divider_output_latch;
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================================
	// checks
	a_lane_broadcast: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_VXOR && elem == 4'hb) |=> vec_wb.data[5] ==
		($past(issue.first_vector_source[5]) ^ $past(issue.second_vector_source[3])))
		else $error("broadcast lane wrong");
	a_rsq_low_out: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_RSQ) |=> vec_wb.valid && vec_wb.data[$past(dest_lane)] ==
		divider_output_latch[15:0])
		else $error("rsq low half not written");
	a_rsqh_high_out: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_RSQH) |=> vec_wb.data[$past(dest_lane)] ==
		$past(divider_output_latch[31:16]))
		else $error("rsqh high half wrong");
	a_rsqh_latch: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_RSQH) |=> divider_input_latch == {$past(src), 16'h0000})
		else $error("rsqh upper half not latched");
	a_rsql_merge: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_RSQL) |=> divider_input_latch[31:16] == $past(divider_input_latch[31:16]))
		else $error("rsql lost upper half");
	a_sar_slice: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_SAR && elem == SLICE_HI) |=> vec_wb.data[0] == $past(acc[0][47:32])
		&& acc[0][47:32] == $past(issue.first_vector_source[0]))
		else $error("accumulator slice access wrong");
	a_sub_clears: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_SUB) |=> carry_flag_register == 16'h0000)
		else $error("carry flags not cleared");
	a_sub_clamp: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_SUB && issue.first_vector_source[1] == 16'h8000 &&
		issue.second_vector_source[1] == 16'h0001 && elem == 4'h0) |=> vec_wb.data[1] == 16'h8000)
		else $error("subtract not saturated");
	a_subc_flags: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_SUBC) |=> carry_flag_register[8] ==
		($past(issue.first_vector_source[0]) != $past(sec_sel[0]))
		&& acc[0][15:0] == vec_wb.data[0])
		else $error("borrow flags wrong");
	a_xor_gpr: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_XOR) |=> gpr_wb.valid &&
		gpr_wb.data == ($past(issue.general_source_one) ^ $past(issue.general_source_two)))
		else $error("register xor wrong");
	a_xori_zext: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_XORI) |=> gpr_wb.data[31:16] == $past(issue.general_source_one[31:16]))
		else $error("immediate not zero extended");
	a_rsq_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_RSQ && src == 16'h0000) |=> divider_output_latch == RSQ_ZERO_RESULT)
		else $error("zero source result wrong");
	a_rsq_acc_copy: assert property (@(posedge pclk) disable iff (!presetn)
		is_rsq_any |=> acc[7][15:0] == $past(src) && acc[0][15:0] == $past(src))
		else $error("accumulator copy missing");
endmodule
`default_nettype wire

// ===== vrx_issue_model.sv
// issue pipeline model that hands instructions to the datapath
`default_nettype none
module vrx_issue_model (
	input wire logic pclk,
	input wire logic presetn,
	output vrx_pkg::vrx_issue_t issue
);
	timeunit 1ns;
	timeprecision 1ps;
	import vrx_pkg::*;
	// ==========================================================================
	// idle until a send, one instruction held for exactly one edge
	initial begin
		issue = '0;
	end
	task automatic send(input logic [31:0] ins, input logic [7:0][15:0] a,
		input logic [7:0][15:0] b, input logic [31:0] g1, input logic [31:0] g2,
		input int gap);
		repeat (gap) @(posedge pclk);
		@(posedge pclk);
		issue <= '{valid: 1'b1, instr: ins, first_vector_source: a,
			second_vector_source: b, general_source_one: g1, general_source_two: g2};
		@(posedge pclk);
		issue <= '{valid: 1'b0, instr: ~ins, first_vector_source: ~a,
			second_vector_source: ~b, general_source_one: ~g1, general_source_two: ~g2};
	endtask
endmodule
`default_nettype wire

// ===== tb_vector_rsq_sub_xor_datapath.sv
// self-checking bench for the vector datapath
`default_nettype none
module tb_vector_rsq_sub_xor_datapath;
	timeunit 1ns;
	timeprecision 1ps;
	import vrx_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	vrx_issue_t issue;
	vrx_vec_wb_t vec_wb;
	vrx_gpr_wb_t gpr_wb;
	int n_errors = 0;
	int checks = 0;
	logic [7:0][15:0] va, vb, ve;
	logic [31:0] rd;
	logic er;
	logic [16:0] d;
	always #20 pclk = ~pclk;
	vrx_datapath dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .issue(issue), .vec_wb(vec_wb), .gpr_wb(gpr_wb));
	vrx_issue_model u_src (.pclk(pclk), .presetn(presetn), .issue(issue));
	// ==========================================================================
	// reporting
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_vec(input string what, input logic [7:0][15:0] exp, input logic [7:0] m);
		checks++;
		if (vec_wb.valid !== 1'b1 || vec_wb.vector_destination !== 5'h07 ||
			vec_wb.lane_mask !== m ||
			(vec_wb.data & {{16{m[7]}}, {16{m[6]}}, {16{m[5]}}, {16{m[4]}},
			{16{m[3]}}, {16{m[2]}}, {16{m[1]}}, {16{m[0]}}}) !== (exp & {{16{m[7]}},
			{16{m[6]}}, {16{m[5]}}, {16{m[4]}}, {16{m[3]}}, {16{m[2]}}, {16{m[1]}}, {16{m[0]}}})) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, vec_wb.data);
		end
	endtask
	// ==========================================================================
	// bus and issue helpers
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			if (n > 20) begin
				n_errors++;
				tally_and_finish();
			end
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [31:0] vi(logic [5:0] fn, logic [3:0] e, logic [4:0] s);
		return {OPC_VECTOR_UNIT, 1'b1, e, 5'h03, s, 5'h07, fn};
	endfunction
	function automatic int lane(logic [3:0] e, int i);
		if (e[3]) return e[2:0];
		if (e[3:2] == 2'b01) return e[1:0] + (i & 4'hc);
		if (e[3:1] == 3'b001) return e[0] + (i & 4'he);
		return i;
	endfunction
	task automatic run(input logic [31:0] ins, input logic [31:0] g1, input logic [31:0] g2);
		u_src.send(ins, va, vb, g1, g2, 0);
		#1;
	endtask
	// ==========================================================================
	// scenarios
	task automatic t_sub();
		apb(1'b1, ADDR_CARRY, 32'h0000_00ff, rd, er);
		va = '{16'h0700, 16'h0600, 16'h0500, 16'h0400, 16'h0300, 16'h0000, 16'h8000, 16'h7fff};
		vb = '{16'h0007, 16'h0006, 16'h0005, 16'h0004, 16'h0003, 16'h0000, 16'h0001, 16'hfffe};
		for (int i = 0; i < 8; i++) begin
			ve[i] = va[i] - vb[i] - 16'h0001;
		end
		ve[0] = 16'h7fff;
		ve[1] = 16'h8000;
		ve[2] = 16'hffff;
		run(vi(FN_SUB, 4'h0, 5'h01), 32'h0, 32'h0);
		chk_vec("vsub", ve, 8'hff);
		apb(1'b0, ADDR_CARRY, 32'h0, rd, er);
		chk32("carry after vsub", 32'h0, rd);
		$display("test sub done");
	endtask
	task automatic t_subc();
		logic [15:0] fl;
		va = '{16'h8000, 16'h0001, 16'h0100, 16'h0004, 16'h0003, 16'hffff, 16'h0000, 16'h0005};
		vb = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666, 16'h7777, 16'h0005};
		fl = 16'h0;
		for (int i = 0; i < 8; i++) begin
			d = {1'b0, va[i]} - {1'b0, vb[0]};
			ve[i] = d[15:0];
			fl[i] = d[16];
			fl[i + 8] = (d != 17'h0);
		end
		run(vi(FN_SUBC, 4'h8, 5'h01), 32'h0, 32'h0);
		chk_vec("vsubc", ve, 8'hff);
		apb(1'b0, ADDR_CARRY, 32'h0, rd, er);
		chk32("carry after vsubc", {16'h0, fl}, rd);
		va = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6, 16'h7};
		run(vi(FN_SAR, SLICE_LO, 5'h01), 32'h0, 32'h0);
		chk_vec("acc low", ve, 8'hff);
		run(vi(FN_SAR, SLICE_LO, 5'h01), 32'h0, 32'h0);
		chk_vec("acc low written", va, 8'hff);
		run(vi(FN_SAR, SLICE_MID, 5'h01), 32'h0, 32'h0);
		chk_vec("acc mid", '0, 8'hff);
		run(vi(FN_SAR, SLICE_MID, 5'h01), 32'h0, 32'h0);
		chk_vec("acc mid written", va, 8'hff);
		run(vi(FN_SAR, SLICE_HI, 5'h01), 32'h0, 32'h0);
		chk_vec("acc high", '0, 8'hff);
		run(vi(FN_SAR, SLICE_HI, 5'h01), 32'h0, 32'h0);
		chk_vec("acc high written", va, 8'hff);
		run(vi(FN_SAR, 4'h3, 5'h01), 32'h0, 32'h0);
		chk32("acc bad slice", 32'h0, {31'h0, vec_wb.valid});
		$display("test subc done");
	endtask
	task automatic t_xor();
		logic [3:0] es [8] = '{4'h0, 4'h3, 4'h2, 4'h5, 4'h6, 4'h8, 4'hb, 4'hf};
		va = '{16'hf0f0, 16'h0ff0, 16'h1234, 16'h5555, 16'haaaa, 16'h0001, 16'h8000, 16'hffff};
		vb = '{16'h0808, 16'h0707, 16'h0606, 16'h0505, 16'h0404, 16'h0303, 16'h0202, 16'h0101};
		foreach (es[k]) begin
			for (int i = 0; i < 8; i++) begin
				ve[i] = va[i] ^ vb[lane(es[k], i)];
			end
			run(vi(FN_VXOR, es[k], 5'h01), 32'h0, 32'h0);
			chk_vec("vxor", ve, 8'hff);
		end
		run(vi(FN_SAR, SLICE_LO, 5'h01), 32'h0, 32'h0);
		chk_vec("acc after vxor", ve, 8'hff);
		run({OPC_REGISTER_OP, 5'h01, 5'h02, 5'h09, 5'h00, FN_XOR}, 32'hdead_0f0f, 32'h1234_ffff);
		chk32("xor", 32'hcc99_f0f0, gpr_wb.data);
		chk32("xor dest", {26'h0, 1'b1, 5'h09}, {26'h0, gpr_wb.valid, gpr_wb.dest});
		run({OPC_XORI, 5'h01, 5'h0b, 16'h8001}, 32'hffff_0000, 32'h0);
		chk32("xori", 32'hffff_8001, gpr_wb.data);
		chk32("xori dest", {26'h0, 1'b1, 5'h0b}, {26'h0, gpr_wb.valid, gpr_wb.dest});
		$display("test xor done");
	endtask
	task automatic t_rsq();
		vb = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h1234, 16'h0};
		run(vi(FN_RSQ, 4'hb, 5'h05), 32'h0, 32'h0);
		chk_vec("rsq zero", {8{16'hffff}}, 8'h20);
		apb(1'b0, ADDR_DIV_OUT, 32'h0, rd, er);
		chk32("divider out", RSQ_ZERO_RESULT, rd);
		run(vi(FN_RSQH, 4'h9, 5'h02), 32'h0, 32'h0);
		chk_vec("rsqh", {8{16'h7fff}}, 8'h04);
		apb(1'b0, ADDR_DIV_IN, 32'h0, rd, er);
		chk32("divider in", 32'h1234_0000, rd);
		run(vi(FN_SAR, SLICE_LO, 5'h01), 32'h0, 32'h0);
		chk_vec("acc copy", {8{16'h1234}}, 8'hff);
		run(vi(FN_RSQL, 4'h8, 5'h06), 32'h0, 32'h0);
		chk_vec("rsql", {8{16'hffff}}, 8'h40);
		apb(1'b0, ADDR_DIV_IN, 32'h0, rd, er);
		chk32("divider merged", 32'h1234_0000, rd);
		vb[2] = 16'hffff;
		run(vi(FN_RSQ, 4'ha, 5'h03), 32'h0, 32'h0);
		chk_vec("rsq negative", {8{16'hc000}}, 8'h08);
		apb(1'b0, ADDR_DIV_OUT, 32'h0, rd, er);
		chk32("divider out negative", 32'ha57d_c000, rd);
		run(vi(FN_RSQH, 4'h9, 5'h04), 32'h0, 32'h0);
		chk_vec("rsqh negative", {8{16'ha57d}}, 8'h10);
		apb(1'b0, 12'h00c, 32'h0, rd, er);
		chk32("unmapped", 32'h1, {31'h0, er});
		$display("test rsq done");
	endtask
	// ==========================================================================
	// main sequence
	initial begin
		va = '0;
		vb = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CARRY, 32'h0, rd, er);
		chk32("carry reset", {16'h0, CARRY_RST}, rd);
		t_sub();
		t_subc();
		t_xor();
		t_rsq();
		tally_and_finish();
	end
	initial begin
		#2ms;
		n_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
